// File: logic/ebpt_timer.sv
// eight bit period timer with prescaler, postscaler and hardware limit modes
//
// Behaviour
// [R1] count and period registers, read/write, 8-bit
// [R2] count increments on every prescaler tick
// [R3] match with period clears count, advances postscaler
// [R4] prescaler ratio 1:1 to 1:128
// [R5] postscaler ratio 1:1 to 1:16
// [R6] postscale match pulses output, clears postscaler
// [R7] gate modes halt count while gate inactive
// [R8] reset modes clear count on level/edge
// [R9] reset source select picks external signal
// [R10] reset clears count, period loads all ones
// [R11] scalers clear on count/control write, resets
// [R12] control write leaves count unchanged
// [R13] one-shot match clears on, stops timer
// [R14] one-shot postscale beyond zero has no effect
// [R15] monostable keeps on, external event restarts
// [R16] postscale match sets flag; irq needs enable
// [R17] flag set on instruction clock, software clears
// [R18] prescaler sync aligns output to instruction clock
// [R19] software uses prescaler sync only when slow
// [R20] control sync: on follows timer input clock
// [R21] no control sync: on follows instruction clock
// [R22] postscaled output and period match for peripherals
// [R23] mode field selects mode; debug ignores triggers
// [R24] source spaces edges six, levels three clocks
// [R25] free-running interval is period plus one
`default_nettype none

module ebpt_timer #(
    parameter int N_ERS = 16
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // pins from outside the clock domain
    input  wire logic              tmr_clk_pin,
    input  wire logic [N_ERS-1:0]  external_reset_signal,
    input  wire logic              debug_mode,
    // outputs to other peripherals
    output logic                   postscaled_output,
    output logic                   period_match,
    output logic                   match_irq
);

    if (N_ERS < 1 || N_ERS > ebpt_pkg::ERS_MAX) begin : g_chk
        $error("N_ERS must lie between 1 and 16");
    end

    function automatic logic [6:0] pre_limit(input logic [2:0] sel);
        pre_limit = 7'((8'h01 << sel) - 8'h01);
    endfunction : pre_limit

    // software state
    logic [7:0] count_q;
    logic [7:0] period_q;
    logic       on_q;
    logic [2:0] pre_sel_q;
    logic [3:0] postscale_select_q;
    logic       prescaler_sync_bit_q;
    logic       control_sync_bit_q;
    logic [4:0] mode_q;
    logic [3:0] reset_source_select_q;
    logic       clk_sel_q;
    logic       match_interrupt_enable_q;
    logic       flag_q;

    // synchronised pins
    logic [N_ERS+1:0] sync_s;
    logic             dbg_s;
    logic             pin_s;
    logic [15:0]      ers_pad;

    ebpt_sync #(.W(N_ERS + 2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d_in    ({debug_mode, tmr_clk_pin, external_reset_signal}),
        .q_out   (sync_s)
    );

    assign dbg_s   = sync_s[N_ERS+1];
    assign pin_s   = sync_s[N_ERS];
    assign ers_pad = 16'(sync_s[N_ERS-1:0]);

    // instruction clock enable, bus clock divided by four
    logic [1:0] ic_cnt_q;
    logic       ic_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ic_cnt_q <= 2'h0;
        end else begin
            ic_cnt_q <= 2'(ic_cnt_q + 2'h1);
        end
    end

    assign ic_en = (ic_cnt_q == ebpt_pkg::IC_LAST);

    // apb decode; no wait state, read data registered in the setup phase
    logic setup;
    logic wr_en;
    logic hit;
    logic wr_cnt;
    logic wr_per;
    logic wr_ctrl;
    logic wr_lim;
    logic wr_rsel;
    logic wr_csel;
    logic wr_int;
    logic [31:0] rd_val;

    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pready && pwrite;
    assign wr_cnt  = wr_en && paddr == ebpt_pkg::OFF_COUNT;
    assign wr_per  = wr_en && paddr == ebpt_pkg::OFF_PERIOD;
    assign wr_ctrl = wr_en && paddr == ebpt_pkg::OFF_CTRL;
    assign wr_lim  = wr_en && paddr == ebpt_pkg::OFF_LIMIT;
    assign wr_rsel = wr_en && paddr == ebpt_pkg::OFF_RSTSEL;
    assign wr_csel = wr_en && paddr == ebpt_pkg::OFF_CLKSEL;
    assign wr_int  = wr_en && paddr == ebpt_pkg::OFF_INT;

    // read mux, unmapped reads zero with an error
    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0;
        unique case (paddr)
            ebpt_pkg::OFF_COUNT:  rd_val[7:0] = count_q;
            ebpt_pkg::OFF_PERIOD: rd_val[7:0] = period_q;
            ebpt_pkg::OFF_CTRL:   rd_val[7:0] = {on_q, pre_sel_q, postscale_select_q};
            ebpt_pkg::OFF_LIMIT:  rd_val[7:0] = {prescaler_sync_bit_q, control_sync_bit_q, 1'b0, mode_q};
            ebpt_pkg::OFF_RSTSEL: rd_val[3:0] = reset_source_select_q;
            ebpt_pkg::OFF_CLKSEL: rd_val[0]   = clk_sel_q;
            ebpt_pkg::OFF_INT:    rd_val[1:0] = {match_interrupt_enable_q, flag_q};
            default:              hit         = 1'b0;
        endcase
    end

    // apb answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit;
            if (setup) begin
                prdata <= pwrite ? 32'h0 : rd_val;
            end
        end
    end

    // plain configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_q                 <= ebpt_pkg::PERIOD_RST; // [R10]
            pre_sel_q                <= 3'h0;
            postscale_select_q       <= 4'h0;
            prescaler_sync_bit_q     <= 1'b0;
            control_sync_bit_q       <= 1'b0;
            mode_q                   <= 5'h00;
            reset_source_select_q    <= 4'h0;
            clk_sel_q                <= 1'b0;
            match_interrupt_enable_q <= 1'b0;
        end else begin
            if (wr_per) begin
                period_q <= pwdata[7:0]; // [R1]
            end
            if (wr_ctrl) begin
                pre_sel_q          <= pwdata[ebpt_pkg::CTRL_PRE_LSB +: 3]; // [R4]
                postscale_select_q <= pwdata[ebpt_pkg::CTRL_POST_LSB +: 4]; // [R5]
            end
            if (wr_lim) begin
                prescaler_sync_bit_q <= pwdata[ebpt_pkg::LIM_PRESCALER_SYNC_BIT_BIT];
                control_sync_bit_q   <= pwdata[ebpt_pkg::LIM_CONTROL_SYNC_BIT_BIT];
                mode_q               <= pwdata[ebpt_pkg::LIM_MODE_LSB +: 5]; // [R23]
            end
            if (wr_rsel) begin
                reset_source_select_q <= pwdata[3:0]; // [R9]
            end
            if (wr_csel) begin
                clk_sel_q <= pwdata[0];
            end
            if (wr_int) begin
                match_interrupt_enable_q <= pwdata[ebpt_pkg::INT_IE_BIT];
            end
        end
    end

    // external reset signal edges; debug masks every trigger
    logic ers;
    logic ers_prev_q;
    logic pin_prev_q;
    logic rise;
    logic fall;

    assign ers  = ers_pad[reset_source_select_q]; // [R9]
    assign rise = ers && !ers_prev_q && !dbg_s; // [R23]
    assign fall = !ers && ers_prev_q && !dbg_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ers_prev_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            ers_prev_q <= ers;
            pin_prev_q <= pin_s;
        end
    end

    // mode decode
    logic [1:0] grp;
    logic [2:0] sub;
    logic       gate_ok;
    logic       edge_rst;
    logic       lvl_rst;
    logic       start_evt;
    logic       needs_start;

    assign grp = mode_q[4:3];
    assign sub = mode_q[2:0];

    always_comb begin
        gate_ok     = 1'b1;
        edge_rst    = 1'b0;
        lvl_rst     = 1'b0;
        start_evt   = 1'b0;
        needs_start = 1'b0;
        unique case (grp)
            ebpt_pkg::GRP_FREE: begin
                unique case (sub)
                    3'h1: gate_ok = ers || dbg_s; // [R7]
                    3'h2: gate_ok = !ers || dbg_s; // [R7]
                    3'h3: edge_rst = rise || fall; // [R8]
                    3'h4: edge_rst = rise;
                    3'h5: edge_rst = fall;
                    3'h6: lvl_rst = !ers && !dbg_s; // [R8]
                    3'h7: lvl_rst = ers && !dbg_s;
                    default: gate_ok = 1'b1;
                endcase
            end
            ebpt_pkg::GRP_ONESHOT: begin
                needs_start = (sub != 3'h0);
                start_evt   = (sub == 3'h1 || sub == 3'h4 || sub == 3'h6) ? rise : fall;
                if (sub == 3'h3) begin
                    start_evt = rise || fall;
                end
                edge_rst = (sub == 3'h4) ? rise : ((sub == 3'h5) ? fall : 1'b0);
                lvl_rst  = !dbg_s && ((sub == 3'h6 && !ers) || (sub == 3'h7 && ers));
            end
            ebpt_pkg::GRP_MONO: begin
                needs_start = 1'b1;
                gate_ok     = (sub != 3'h0) && (sub < 3'h4);
                start_evt   = (sub == 3'h1) ? rise : ((sub == 3'h2) ? fall : (rise || fall)); // [R15]
            end
            default: gate_ok = 1'b0; // reserved modes never count
        endcase
    end

    // on bit sync: timer input or instruction clock
    logic tin;
    logic on_eff_q;
    logic pre_in;

    assign tin = clk_sel_q ? (pin_s && !pin_prev_q) : ic_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_eff_q <= 1'b0;
        end else if (control_sync_bit_q ? tin : ic_en) begin
            on_eff_q <= on_q; // [R20] [R21]
        end
    end

    // with control sync the edge that moves on is consumed
    assign pre_in = tin && on_eff_q && (on_eff_q == on_q || !control_sync_bit_q); // [R20]

    // prescaler and its optional alignment to the instruction clock
    logic [6:0] pre_cnt_q;
    logic       pre_out;
    logic       pend_q;
    logic       tick;
    logic       ext_rst_evt;
    logic       scl_clr;

    assign ext_rst_evt = edge_rst || lvl_rst;
    assign scl_clr     = wr_cnt || wr_ctrl || ext_rst_evt; // [R11]
    assign pre_out     = pre_in && (pre_cnt_q == pre_limit(pre_sel_q)); // [R4]
    // only sound when the prescaler is slower than the instruction clock
    assign tick        = prescaler_sync_bit_q ? (ic_en && pend_q) : pre_out; // [R18]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_q <= 7'h00;
        end else if (scl_clr) begin
            pre_cnt_q <= 7'h00; // [R11]
        end else if (pre_in) begin
            pre_cnt_q <= pre_out ? 7'h00 : 7'(pre_cnt_q + 7'h01);
        end
    end

    // pending tick, set wins over its own release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else if (scl_clr || !prescaler_sync_bit_q) begin
            pend_q <= 1'b0;
        end else if (pre_out) begin
            pend_q <= 1'b1; // [R18]
        end else if (tick) begin
            pend_q <= 1'b0;
        end
    end

    // count register
    logic run_q;
    logic active;
    logic count_en;
    logic match;

    assign active   = on_q && on_eff_q && gate_ok && !lvl_rst && (!needs_start || run_q);
    assign count_en = tick && active && !wr_cnt && !wr_ctrl && !edge_rst; // [R7] [R12]
    assign match    = count_en && (count_q == period_q); // [R3]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= ebpt_pkg::COUNT_RST; // [R10]
        end else if (wr_cnt) begin
            count_q <= pwdata[7:0]; // [R1]
        end else if (ext_rst_evt) begin
            count_q <= 8'h00; // [R8]
        end else if (count_en) begin
            count_q <= match ? 8'h00 : 8'(count_q + 8'h01); // [R2] [R3] [R25]
        end
    end

    // start state for triggered one-shot and monostable modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else if (!on_q) begin
            run_q <= 1'b0;
        end else if (start_evt && on_eff_q) begin
            run_q <= 1'b1; // [R15]
        end else if (match && grp != ebpt_pkg::GRP_FREE) begin
            run_q <= 1'b0;
        end
    end

    // on bit; one-shot match turns it off, monostable leaves it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q <= 1'b0;
        end else if (wr_ctrl) begin
            on_q <= pwdata[ebpt_pkg::CTRL_ON_BIT];
        end else if (match && grp == ebpt_pkg::GRP_ONESHOT) begin
            on_q <= 1'b0; // [R13]
        end
    end

    // postscaler; cleared on restart, so one-shot ratios above 1:1 never fire
    logic [3:0] post_cnt_q;
    logic       post_hit;

    assign post_hit = match && (post_cnt_q == postscale_select_q); // [R6]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_cnt_q <= 4'h0;
        end else if (scl_clr) begin
            post_cnt_q <= 4'h0; // [R11] [R14]
        end else if (match) begin
            post_cnt_q <= post_hit ? 4'h0 : 4'(post_cnt_q + 4'h1); // [R5] [R6]
        end
    end

    // outputs: postscaled pulse lasts one timer tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            postscaled_output <= 1'b0;
            period_match      <= 1'b0;
        end else begin
            period_match <= match; // [R22]
            if (post_hit) begin
                postscaled_output <= 1'b1; // [R6] [R22]
            end else if (tick || scl_clr || !on_eff_q) begin // stopped timer gives no tick
                postscaled_output <= 1'b0;
            end
        end
    end

    // interrupt flag set on the instruction clock, set beats clear
    logic flag_pend_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_pend_q <= 1'b0;
        end else if (post_hit) begin
            flag_pend_q <= 1'b1; // [R16]
        end else if (ic_en) begin
            flag_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q    <= 1'b0;
            match_irq <= 1'b0;
        end else begin
            if (ic_en && flag_pend_q) begin
                flag_q <= 1'b1; // [R17]
            end else if (wr_int && !pwdata[ebpt_pkg::INT_FLAG_BIT]) begin
                flag_q <= 1'b0; // [R17]
            end
            match_irq <= flag_q && match_interrupt_enable_q; // [R16]
        end
    end

    // checks
    a_count_step: // [R2]
    assert property (@(posedge pclk) disable iff (!presetn)
        count_en && !match |=> count_q == $past(count_q) + 8'h01)
        else $error("count did not step on a tick");

    a_period_wrap: // [R3]
    assert property (@(posedge pclk) disable iff (!presetn)
        count_en && count_q == period_q |=> count_q == 8'h00 && $rose(period_match))
        else $error("period match did not wrap count");

    a_scaler_clear: // [R11]
    assert property (@(posedge pclk) disable iff (!presetn)
        wr_cnt || wr_ctrl |=> pre_cnt_q == 7'h00 && post_cnt_q == 4'h0)
        else $error("scalers not cleared by register write");

    a_ctrl_keeps_count: // [R12]
    assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && !ext_rst_evt |=> $stable(count_q))
        else $error("control write changed count");

    a_oneshot_stop: // [R13]
    assert property (@(posedge pclk) disable iff (!presetn)
        match && grp == ebpt_pkg::GRP_ONESHOT && !wr_ctrl |=> !on_q ##1 !count_en)
        else $error("one-shot did not stop");

    a_mono_keeps_on: // [R15]
    assert property (@(posedge pclk) disable iff (!presetn)
        match && grp == ebpt_pkg::GRP_MONO && !wr_ctrl |=> on_q && !run_q)
        else $error("monostable lost on bit");

    a_post_pulse: // [R6]
    assert property (@(posedge pclk) disable iff (!presetn)
        $rose(postscaled_output) |-> $past(match) && $past(post_cnt_q) == $past(postscale_select_q))
        else $error("postscaled pulse without postscale match");

    a_flag_on_ic: // [R17]
    assert property (@(posedge pclk) disable iff (!presetn)
        post_hit |-> ##[1:5] flag_q)
        else $error("flag not set within an instruction clock");

    a_flag_aligned: // [R17]
    assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flag_q) |-> $past(ic_en))
        else $error("flag set off the instruction clock");

    a_irq_enable: // [R16]
    assert property (@(posedge pclk) disable iff (!presetn)
        match_irq |-> $past(match_interrupt_enable_q) && $past(flag_q))
        else $error("interrupt request without enable");

    a_gate_halt: // [R7]
    assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == 5'h01 && !ers && !dbg_s && !wr_cnt |=> $stable(count_q))
        else $error("count moved with gate closed");

endmodule : ebpt_timer

`default_nettype wire

// File: logic/ebpt_pkg.sv
// constants shared by the eight bit period timer
`default_nettype none

package ebpt_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_COUNT   = 8'h00;
    localparam logic [7:0] OFF_PERIOD  = 8'h04;
    localparam logic [7:0] OFF_CTRL    = 8'h08;
    localparam logic [7:0] OFF_LIMIT   = 8'h0c;
    localparam logic [7:0] OFF_RSTSEL  = 8'h10;
    localparam logic [7:0] OFF_CLKSEL  = 8'h14;
    localparam logic [7:0] OFF_INT     = 8'h18;

    // control register fields
    localparam int CTRL_ON_BIT   = 7;
    localparam int CTRL_PRE_LSB  = 4;
    localparam int CTRL_POST_LSB = 0;

    // limit mode register fields
    localparam int LIM_PRESCALER_SYNC_BIT_BIT = 7;
    localparam int LIM_CONTROL_SYNC_BIT_BIT = 6;
    localparam int LIM_MODE_LSB  = 0;

    // interrupt register fields
    localparam int INT_FLAG_BIT = 0;
    localparam int INT_IE_BIT   = 1;

    // reset values
    localparam logic [7:0] COUNT_RST  = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hff;

    // instruction clock is the bus clock divided by four
    localparam logic [1:0] IC_LAST = 2'h3;

    // mode field groups, bits 4:3
    localparam logic [1:0] GRP_FREE    = 2'h0;
    localparam logic [1:0] GRP_ONESHOT = 2'h1;
    localparam logic [1:0] GRP_MONO    = 2'h2;

    // maximum number of external reset sources
    localparam int ERS_MAX = 16;

endpackage : ebpt_pkg

`default_nettype wire

// File: logic/ebpt_sync.sv
// two flip-flop synchroniser for pins entering the bus clock domain
`default_nettype none

module ebpt_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // asynchronous in, synchronised out
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    logic [W-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule : ebpt_sync

`default_nettype wire

// File: tb/ebpt_partner.sv
// far-side model: external reset sources and timer input clock
`default_nettype none

module ebpt_partner (
    // bus clock
    input  wire logic        pclk,
    // level asked for on source 0
    input  wire logic        ers_lvl,
    // pins toward the timer
    output logic      [15:0] external_reset_signal,
    output logic             tmr_clk_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [14:0] noise_q = 15'h0;
    logic [3:0]  div_q   = 4'h0;
    logic        clk_q   = 1'b0;

    // unselected sources carry a running count, source 1 toggling every cycle, so a wrong select shows
    always @(posedge pclk) begin
        noise_q               <= noise_q + 15'h1;
        external_reset_signal <= {noise_q, ers_lvl};
    end

    // free-running input clock, ten bus clocks a period
    always @(posedge pclk) begin
        div_q <= (div_q == 4'h4) ? 4'h0 : div_q + 4'h1;
        if (div_q == 4'h4) begin
            clk_q <= ~clk_q;
        end
    end
    assign tmr_clk_pin = clk_q;

endmodule : ebpt_partner

`default_nettype wire

// File: tb/ebpt_timer_tb.sv
// self-checking bench for the eight bit period timer
`default_nettype none

module ebpt_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] external_reset_signal;
    logic        tmr_clk_pin, debug_mode, ers_lvl;
    logic        postscaled_output, period_match, match_irq;
    logic [32:0] exp_q[$];
    int          n_mismatch  = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          n_pm = 0;
    int          n_post = 0;
    logic        post_d = 1'b0;

    ebpt_timer #(.N_ERS(16)) ebpt_timer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tmr_clk_pin(tmr_clk_pin), .external_reset_signal(external_reset_signal),
        .debug_mode(debug_mode), .postscaled_output(postscaled_output),
        .period_match(period_match), .match_irq(match_irq));
    ebpt_partner ebpt_partner_i (.pclk(pclk), .ers_lvl(ers_lvl),
        .external_reset_signal(external_reset_signal), .tmr_clk_pin(tmr_clk_pin));

    // 250 MHz bus clock
    always #2 pclk = ~pclk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [32:0] e, input logic [32:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // pulse tallies and a ceiling on run length
    always @(posedge pclk) begin
        n_pm   <= n_pm + int'(period_match === 1'b1);
        n_post <= n_post + int'(postscaled_output === 1'b1 && post_d !== 1'b1);
        post_d <= postscaled_output;
        cyc    <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // read answers taken at the edge that samples pready
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk(exp_q.size() ? exp_q.pop_front() : 33'h1ffffffff, {pslverr, prdata});
        end
    end

    // request held until pready, released, then one idle edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(a, 1'b0, 8'h0);
    endtask : rd

    // stop, clear, then start with a fresh period
    task automatic cfg(input logic [7:0] pr, input logic [7:0] c);
        wr(ebpt_pkg::OFF_CTRL, 8'h0);
        wr(ebpt_pkg::OFF_COUNT, 8'h0);
        wr(ebpt_pkg::OFF_PERIOD, pr);
        wr(ebpt_pkg::OFF_CTRL, c);
    endtask : cfg

    // rise-to-rise spacing; skips a pulse already under way
    task automatic gap(input logic s, output logic [32:0] n);
        n = 33'h0;
        do @(posedge pclk); while ((s ? postscaled_output : period_match) !== 1'b0);
        do @(posedge pclk); while ((s ? postscaled_output : period_match) !== 1'b1);
        do begin
            @(posedge pclk);
            n++;
        end while ((s ? postscaled_output : period_match) !== 1'b0);
        do begin
            @(posedge pclk);
            n++;
        end while ((s ? postscaled_output : period_match) !== 1'b1);
    endtask : gap

    task automatic tally(input int n, input int ep, input int eo);
        int a;
        int b;
        a = n_pm;
        b = n_post;
        repeat (n) @(posedge pclk);
        chk(33'(ep), 33'(n_pm - a));
        chk(33'(eo), 33'(n_post - b));
    endtask : tally

    initial begin
        logic [7:0]  pr;
        logic [32:0] g;
        {presetn, psel, penable, pwrite, paddr, pwdata, ers_lvl, debug_mode} = '0;
        pr = 8'($urandom(32'h3194));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ebpt_pkg::OFF_COUNT, 33'h0);
        rd(ebpt_pkg::OFF_PERIOD, 33'hff);
        wr(ebpt_pkg::OFF_COUNT, 8'h5a);
        wr(ebpt_pkg::OFF_CTRL, 8'h37);
        rd(ebpt_pkg::OFF_COUNT, 33'h5a);
        rd(ebpt_pkg::OFF_CTRL, 33'h37);
        wr(ebpt_pkg::OFF_PERIOD, pr);
        rd(ebpt_pkg::OFF_PERIOD, {25'h0, pr});
        rd(8'h1c, 33'h100000000);
        rd(8'h02, 33'h100000000);
        $display("end of test: registers");
        for (int n = 0; n < 8; n++) begin
            pr = 8'(1 + $urandom % 7);
            cfg(pr, 8'h80 | 8'(n << 4));
            gap(1'b0, g);
            chk(33'(((pr + 1) * 4) << n), g);
        end
        for (int k = 0; k < 16; k++) begin
            pr = 8'(1 + $urandom % 3);
            cfg(pr, 8'h80 | 8'(k));
            gap(1'b1, g);
            chk(33'((pr + 1) * 4 * (k + 1)), g);
        end
        wr(ebpt_pkg::OFF_CLKSEL, 8'h1);
        wr(ebpt_pkg::OFF_LIMIT, 8'hc0);
        cfg(8'h3, 8'h90);
        gap(1'b0, g);
        chk(33'd80, g);
        wr(ebpt_pkg::OFF_LIMIT, 8'h00);
        cfg(8'h3, 8'h80);
        gap(1'b0, g);
        chk(33'd40, g);
        wr(ebpt_pkg::OFF_CLKSEL, 8'h0);
        $display("end of test: scalers");
        wr(ebpt_pkg::OFF_INT, 8'h0);
        repeat (40) @(posedge pclk);
        rd(ebpt_pkg::OFF_INT, 33'h1);
        chk(33'h0, {32'h0, match_irq});
        wr(ebpt_pkg::OFF_CTRL, 8'h0);
        repeat (8) @(posedge pclk);
        wr(ebpt_pkg::OFF_INT, 8'h2);
        rd(ebpt_pkg::OFF_INT, 33'h2);
        wr(ebpt_pkg::OFF_CTRL, 8'h80);
        repeat (40) @(posedge pclk);
        chk(33'h1, {32'h0, match_irq});
        wr(ebpt_pkg::OFF_CTRL, 8'h0);
        repeat (8) @(posedge pclk);
        wr(ebpt_pkg::OFF_INT, 8'h0);
        repeat (3) @(posedge pclk);
        chk(33'h0, {32'h0, match_irq});
        $display("end of test: interrupt");
        wr(ebpt_pkg::OFF_LIMIT, 8'h08);
        cfg(8'h2, 8'h85);
        tally(60, 1, 0);
        rd(ebpt_pkg::OFF_CTRL, 33'h05);
        wr(ebpt_pkg::OFF_LIMIT, 8'h0c);
        cfg(8'h2, 8'h80);
        tally(40, 0, 0);
        ers_lvl <= 1'b1;
        tally(40, 1, 1);
        ers_lvl <= 1'b0;
        wr(ebpt_pkg::OFF_LIMIT, 8'h11);
        wr(ebpt_pkg::OFF_RSTSEL, 8'h0);
        cfg(8'h2, 8'h80);
        tally(40, 0, 0);
        ers_lvl <= 1'b1;
        tally(40, 1, 1);
        ers_lvl <= 1'b0;
        tally(40, 0, 0);
        rd(ebpt_pkg::OFF_CTRL, 33'h80);
        ers_lvl <= 1'b1;
        tally(40, 1, 1);
        $display("end of test: one-shot and monostable");
        wr(ebpt_pkg::OFF_LIMIT, 8'h01);
        ers_lvl <= 1'b0;
        cfg(8'h2, 8'h80);
        tally(40, 0, 0);
        ers_lvl <= 1'b1;
        gap(1'b0, g);
        chk(33'd12, g);
        wr(ebpt_pkg::OFF_LIMIT, 8'h07);
        cfg(8'h2, 8'h80);
        tally(40, 0, 0);
        rd(ebpt_pkg::OFF_COUNT, 33'h0);
        debug_mode <= 1'b1;
        gap(1'b0, g);
        chk(33'd12, g);
        $display("end of test: gate, reset and debug");
        give_verdict();
    end

endmodule : ebpt_timer_tb

`default_nettype wire
